// ### include/phy_an_pkg.sv
package phy_an_pkg;
  localparam int          IDX_W          = 4;
  localparam logic [3:0]  IDX_CONTROL    = 4'h0;
  localparam logic [3:0]  IDX_STATUS     = 4'h1;
  localparam logic [3:0]  IDX_ID_LOW     = 4'h3;
  localparam logic [3:0]  IDX_ADV        = 4'h4;
  localparam logic [3:0]  IDX_LP_BASE    = 4'h5;
  localparam logic [3:0]  IDX_EXPANSION  = 4'h6;
  localparam logic [3:0]  IDX_NP_TX      = 4'h7;
  localparam logic [3:0]  IDX_NP_RX      = 4'h8;
  localparam int          CTL_SPEED0     = 13;
  localparam int          CTL_AN_EN      = 12;
  localparam int          CTL_RESTART    = 9;
  localparam int          CTL_DUPLEX     = 8;
  localparam int          CTL_SPEED1     = 6;
  localparam int          STS_AN_DONE    = 5;
  localparam int          STS_AN_ABLE    = 3;
  localparam int          PG_NEXT        = 15;
  localparam int          PG_ACK         = 14;
  localparam int          PG_TOGGLE      = 11;
  localparam int          EXP_PD_FAULT   = 4;
  localparam int          EXP_LP_NP      = 3;
  localparam int          EXP_NP_ABLE    = 2;
  localparam int          EXP_PAGE_RX    = 1;
  localparam int          EXP_LP_AN      = 0;
  localparam logic [15:0] ADV_WR_MASK    = 16'hADFF;
  localparam logic [15:0] ADV_RST        = 16'h01E1;
  localparam logic [15:0] LP_WR_MASK     = 16'h0800;
  localparam logic [15:0] NP_TX_WR_MASK  = 16'hB7FF;
  localparam logic [15:0] NP_TX_RST      = 16'h2001;
  localparam logic        AN_EN_RST      = 1'b1;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
endpackage

// ### verilog/sticky_latch.sv
`timescale 1ns/1ps
module sticky_latch (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic event_in,
  input  wire logic read_clr,
  output logic      flag
);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (ce) begin
      flag <= event_in | (flag & ~read_clr);
    end
  end
endmodule

// ### verilog/phy_an_regs.sv
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
module phy_an_regs #(
  parameter logic [5:0] OUI_BITS  = 6'h2A,
  parameter logic [5:0] MODEL_NUM = 6'h15,
  parameter logic [3:0] REV_NUM   = 4'h1
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        page_valid,
  input  wire logic        page_base,
  input  wire logic [15:0] page_word,
  input  wire logic        parallel_fault,
  input  wire logic        an_complete,
  input  wire logic        partner_an_able,
  input  wire logic        tx_page_taken,
  input  wire logic        tx_toggle,
  input  wire logic [1:0]  neg_speed,
  input  wire logic        neg_full_duplex,
  output logic             an_enable,
  output logic             an_restart,
  output logic [15:0]      adv_word,
  output logic [15:0]      np_tx_word,
  output logic [1:0]       link_speed,
  output logic             link_full_duplex
);
  import phy_an_pkg::*;

  // OUI_BITS, MODEL_NUM and REV_NUM defaults are arbitrary identification values
  if (IDX_W < 4) begin : g_idx_check
    $error("Index width too small for the register map");
  end

  function automatic logic [15:0] merge(input logic [15:0] old_val,
                                        input logic [15:0] new_val,
                                        input logic [15:0] mask);
    merge = (old_val & ~mask) | (new_val & mask);
  endfunction

  function automatic logic [15:0] low16(input logic [31:0] word);
    low16 = word[15:0];
  endfunction

  // Bus decode
  logic             wr_pend;
  logic [IDX_W-1:0] wr_idx;
  logic [5:0]       model_num;
  logic [3:0]       rev_num;
  logic [1:0]       speed_sel;
  logic             duplex_sel;
  logic [15:0]      lp_base;
  logic             lp_ack;
  logic [15:0]      np_rx;
  logic             pd_fault_flag;
  logic             page_rx_flag;

  wire              bus_take   = hsel & htrans[1] & hready;
  wire [IDX_W-1:0]  acc_idx    = haddr[IDX_W+1:2];
  wire              addr_in    = (haddr[31:IDX_W+2] == '0);
  wire              rd_take    = bus_take & ~hwrite;
  wire              wr_take    = bus_take & hwrite;
  wire [15:0]       wdata      = low16(hwdata);
  wire              wr_control = wr_pend & (wr_idx == IDX_CONTROL);
  wire              wr_id      = wr_pend & (wr_idx == IDX_ID_LOW);
  wire              wr_adv     = wr_pend & (wr_idx == IDX_ADV);
  wire              wr_lp      = wr_pend & (wr_idx == IDX_LP_BASE);
  wire              wr_np_tx   = wr_pend & (wr_idx == IDX_NP_TX);
  wire              rd_exp     = rd_take & addr_in & (acc_idx == IDX_EXPANSION);
  wire              base_in    = page_valid & page_base;
  wire              next_in    = page_valid & ~page_base;

  // Read words
  wire [15:0] control_word;
  wire [15:0] status_word;
  wire [15:0] id_word;
  wire [15:0] lp_word;
  wire [15:0] exp_word;
  wire [15:0] rd_word;

  assign control_word = (16'h0001 << CTL_SPEED0) & {16{speed_sel[0]}}
                      | (16'h0001 << CTL_AN_EN) & {16{an_enable}}
                      | (16'h0001 << CTL_DUPLEX) & {16{duplex_sel}}
                      | (16'h0001 << CTL_SPEED1) & {16{speed_sel[1]}};
  assign status_word  = (16'h0001 << STS_AN_DONE) & {16{an_complete & an_enable}}
                      | (16'h0001 << STS_AN_ABLE);
  assign id_word      = {OUI_BITS, model_num, rev_num};
  assign lp_word      = lp_base | ((16'h0001 << PG_ACK) & {16{lp_ack}});
  assign exp_word     = (16'h0001 << EXP_PD_FAULT) & {16{pd_fault_flag}}
                      | (16'h0001 << EXP_LP_NP) & {16{lp_base[PG_NEXT]}}
                      | (16'h0001 << EXP_NP_ABLE)
                      | (16'h0001 << EXP_PAGE_RX) & {16{page_rx_flag}}
                      | (16'h0001 << EXP_LP_AN) & {16{partner_an_able}};

  assign rd_word = !addr_in                  ? 16'h0000 :
                   acc_idx == IDX_CONTROL    ? control_word :
                   acc_idx == IDX_STATUS     ? status_word :
                   acc_idx == IDX_ID_LOW     ? id_word :
                   acc_idx == IDX_ADV        ? adv_word :
                   acc_idx == IDX_LP_BASE    ? lp_word :
                   acc_idx == IDX_EXPANSION  ? exp_word :
                   acc_idx == IDX_NP_TX      ? np_tx_word :
                   acc_idx == IDX_NP_RX      ? np_rx :
                   16'h0000;

  // Bus slave: reads answer with no wait, writes take one wait cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_pend   <= 1'b0;
      wr_idx    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else if (ce) begin
      wr_pend   <= wr_take & addr_in;
      wr_idx    <= acc_idx;
      hreadyout <= ~wr_take;
      hresp     <= 1'b0;
      if (rd_take) begin
        hrdata <= {16'h0000, rd_word};
      end
    end
  end

  // Control, own mode bits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      an_enable  <= AN_EN_RST;
      an_restart <= 1'b0;
      speed_sel  <= 2'h0;
      duplex_sel <= 1'b0;
    end else if (ce) begin
      an_restart <= wr_control & wdata[CTL_RESTART];
      if (wr_control) begin
        an_enable  <= wdata[CTL_AN_EN];
        speed_sel  <= {wdata[CTL_SPEED1], wdata[CTL_SPEED0]};
        duplex_sel <= wdata[CTL_DUPLEX];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link_speed       <= 2'h0;
      link_full_duplex <= 1'b0;
    end else if (ce) begin
      link_speed       <= an_enable ? neg_speed : speed_sel;
      link_full_duplex <= an_enable ? neg_full_duplex : duplex_sel;
    end
  end

  // Identifier fields
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      model_num <= MODEL_NUM;
      rev_num   <= REV_NUM;
    end else if (ce && wr_id) begin
      model_num <= wdata[9:4];
      rev_num   <= wdata[3:0];
    end
  end

  // Local advertisement
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      adv_word <= ADV_RST;
    end else if (ce && wr_adv) begin
      adv_word <= merge(adv_word, wdata, ADV_WR_MASK);
    end
  end

  // Partner base page
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lp_base <= 16'h0000;
      lp_ack  <= 1'b0;
    end else if (ce) begin
      if (base_in) begin
        lp_base <= page_word & ~(16'h0001 << PG_ACK) & ~16'h1000;
        lp_ack  <= 1'b1;
      end else if (wr_lp) begin
        lp_base <= merge(lp_base, wdata, LP_WR_MASK);
      end
    end
  end

  // Next page transmit word
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      np_tx_word <= NP_TX_RST;
    end else if (ce) begin
      if (wr_np_tx) begin
        np_tx_word <= merge(np_tx_word, wdata, NP_TX_WR_MASK);
      end
      if (tx_page_taken) begin
        np_tx_word[PG_TOGGLE] <= ~tx_toggle;
      end
    end
  end

  // Partner next page receive word
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      np_rx <= 16'h0000;
    end else if (ce && next_in) begin
      np_rx <= page_word & ~16'h4000 | ((16'h0001 << PG_ACK) & {16{page_word[PG_ACK]}});
    end
  end

  // Latched-high expansion flags
  sticky_latch u_pd_fault (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .event_in (parallel_fault),
    .read_clr (rd_exp),
    .flag     (pd_fault_flag)
  );

  sticky_latch u_page_rx (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .event_in (page_valid),
    .read_clr (rd_exp),
    .flag     (page_rx_flag)
  );

  wire unused_ok = &{1'b0, hsize, hwdata[31:16], haddr[1:0]};
endmodule

// ### tb/an_monitor.sv
`timescale 1ns/1ps
module an_monitor (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        tx_page_taken,
  input wire logic        tx_toggle,
  input wire logic [1:0]  neg_speed,
  input wire logic        an_enable,
  input wire logic        an_restart,
  input wire logic [15:0] adv_word,
  input wire logic [15:0] np_tx_word,
  input wire logic [1:0]  link_speed
);
  wire logic go;
  assign go = ce & hsel & htrans[1] & hready;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_wr_one_wait: assert property (go && hwrite |=> !hreadyout ##1 hreadyout)
    else $error("write wait state wrong");
  a_rd_no_wait: assert property (go && !hwrite |=> hreadyout && hrdata[31:16] == 16'h0)
    else $error("read answer wrong");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_rd_data_holds: assert property (!(go && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
  a_adv_reserved: assert property ((adv_word & 16'h5200) == 16'h0)
    else $error("advertisement reserved bit set");
  a_np_reserved: assert property (np_tx_word[14] == 1'h0)
    else $error("next page reserved bit set");
  a_toggle_inv: assert property (ce && tx_page_taken |=> np_tx_word[11] == !$past(tx_toggle))
    else $error("toggle not inverted");
  a_restart_pulse: assert property (an_restart |=> !an_restart)
    else $error("restart pulse too long");
  a_auto_speed: assert property (ce && an_enable |=> link_speed == $past(neg_speed))
    else $error("forced speed used while negotiating");
endmodule
bind phy_an_regs an_monitor u_an_monitor (.*);

// ### tb/an_partner_model.sv
`timescale 1ns/1ps
module an_partner_model (
  input  wire logic   core_clk,
  output logic        page_valid,
  output logic        page_base,
  output logic [15:0] page_word,
  output logic        parallel_fault,
  output logic        tx_page_taken,
  output logic        tx_toggle,
  output logic        an_complete,
  output logic        partner_an_able,
  output logic [1:0]  neg_speed,
  output logic        neg_full_duplex
);
  initial begin
    {page_valid, page_base, page_word, parallel_fault, tx_page_taken} = '0;
    {tx_toggle, an_complete, partner_an_able, neg_full_duplex} = '0;
    neg_speed = 2'h2;
  end
  // Released word lines show the inverse so a stale value is never mistaken
  task automatic send(input logic base, input logic [15:0] w);
    @(posedge core_clk);
    page_valid <= 1'h1;
    page_base <= base;
    page_word <= w;
    @(posedge core_clk);
    page_valid <= 1'h0;
    page_base <= ~base;
    page_word <= ~w;
    an_complete <= an_complete | base;
    partner_an_able <= 1'h1;
  endtask
  task automatic taken(input logic t);
    @(posedge core_clk);
    tx_page_taken <= 1'h1;
    tx_toggle <= t;
    @(posedge core_clk);
    tx_page_taken <= 1'h0;
    tx_toggle <= ~t;
  endtask
  task automatic fault();
    @(posedge core_clk);
    parallel_fault <= 1'h1;
    @(posedge core_clk);
    parallel_fault <= 1'h0;
  endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, a); end end
module tb;
  import phy_an_pkg::*;
  logic        core_clk = 1'h0, rst = 1'h1, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0, neg_speed, link_speed;
  logic [15:0] page_word, adv_word, np_tx_word;
  logic        hreadyout, hresp, page_valid, page_base, parallel_fault, tx_page_taken;
  logic        tx_toggle, an_complete, partner_an_able, neg_full_duplex;
  logic        an_enable, an_restart, link_full_duplex;
  int          miscompares = 0, total_checks = 0, cycles = 0;
  always #5 core_clk = ~core_clk;
  phy_an_regs u_phy_an_regs (.ce(1'h1), .hsel(1'h1), .hsize(3'h2), .hready(hreadyout), .*);
  an_partner_model u_an_partner_model (.*);
  task automatic conclude();
    $display("Checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] i, input logic [15:0] d,
                     output logic [31:0] q);
    htrans <= HTRANS_NONSEQ;
    haddr <= {26'h0, i, 2'h0};
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task automatic cr(input logic [3:0] i, input logic [15:0] e);
    logic [31:0] q;
    bus(1'h0, i, 16'h0, q);
    `CHK("read", {16'h0, e}, q)
  endtask
  task automatic wr(input logic [3:0] i, input logic [15:0] d);
    logic [31:0] q;
    bus(1'h1, i, d, q);
  endtask
  task automatic t_reset();
    `CHK("an_enable", 1'h1, an_enable)
    cr(IDX_ID_LOW, {6'h2A, 6'h15, 4'h1});
    cr(IDX_ADV, 16'h01E1);
    cr(IDX_LP_BASE, 16'h0000);
    cr(IDX_EXPANSION, 16'h0004);
    cr(IDX_NP_TX, 16'h2001);
    cr(IDX_NP_RX, 16'h0000);
    cr(IDX_STATUS, 16'h0008);
    $display("reset test done");
  endtask
  task automatic t_write();
    logic [3:0]  ix [5] = '{IDX_ID_LOW, IDX_ADV, IDX_LP_BASE, IDX_NP_RX, 4'hF};
    logic [15:0] ex [5] = '{{6'h2A, 10'h3FF}, 16'hADFF, 16'h0800, 16'h0000, 16'h0000};
    for (int k = 0; k < 5; k++) begin
      wr(ix[k], 16'hFFFF);
      cr(ix[k], ex[k]);
    end
    wr(IDX_ADV, 16'h0000);
    `CHK("adv_word", 16'h0000, adv_word)
    cr(IDX_ADV, 16'h0000);
    $display("write test done");
  endtask
  task automatic t_page();
    u_an_partner_model.send(1'h1, 16'h1FE1);
    cr(IDX_LP_BASE, 16'h4FE1);
    cr(IDX_EXPANSION, 16'h0007);
    cr(IDX_EXPANSION, 16'h0005);
    cr(IDX_STATUS, 16'h0028);
    wr(IDX_NP_TX, 16'hFFFF);
    cr(IDX_NP_TX, 16'hB7FF);
    u_an_partner_model.taken(1'h0);
    cr(IDX_NP_TX, 16'hBFFF);
    `CHK("np_tx_word", 16'hBFFF, np_tx_word)
    u_an_partner_model.send(1'h0, 16'hD803);
    cr(IDX_NP_RX, 16'hD803);
    u_an_partner_model.fault();
    cr(IDX_EXPANSION, 16'h0017);
    cr(IDX_EXPANSION, 16'h0005);
    $display("page test done");
  endtask
  task automatic t_ctrl();
    wr(IDX_CONTROL, 16'h3100);
    @(posedge core_clk);
    `CHK("speed", 2'h2, link_speed)
    `CHK("duplex", 1'h0, link_full_duplex)
    wr(IDX_CONTROL, 16'h2100);
    @(posedge core_clk);
    `CHK("speed", 2'h1, link_speed)
    `CHK("duplex", 1'h1, link_full_duplex)
    cr(IDX_STATUS, 16'h0008);
    wr(IDX_CONTROL, 16'h1200);
    `CHK("an_restart", 1'h1, an_restart)
    @(posedge core_clk);
    `CHK("an_restart", 1'h0, an_restart)
    `CHK("an_enable", 1'h1, an_enable)
    `CHK("hresp", 1'h0, hresp)
    $display("control test done");
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    t_reset();
    t_write();
    t_page();
    t_ctrl();
    conclude();
  end
endmodule
